// >>> core/xmb_pkg.sv
/*
  Shared constants and types for the multiply and block-output executor.
  Assumes the core has already fetched the two-byte extended opcode and
  that one processor clock state equals one clk_sys cycle.
*/
package xmb_pkg;

  // Register offsets on the AXI4-Lite slave (byte addresses)
  localparam logic [7:0] ADDR_BC     = 8'h00;
  localparam logic [7:0] ADDR_DE     = 8'h04;
  localparam logic [7:0] ADDR_PTR    = 8'h08;
  localparam logic [7:0] ADDR_SP     = 8'h0C;
  localparam logic [7:0] ADDR_FLAGS  = 8'h10;
  localparam logic [7:0] ADDR_CMD    = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IIO    = 8'h20;

  // Register pair indices, selector code equals index
  localparam logic [1:0] PAIR_BC  = 2'b00;
  localparam logic [1:0] PAIR_DE  = 2'b01;
  localparam logic [1:0] PAIR_PTR = 2'b10;
  localparam logic [1:0] PAIR_SP  = 2'b11;

  // Flag bit positions
  localparam int FLG_S  = 7;
  localparam int FLG_Z  = 6;
  localparam int FLG_H  = 4;
  localparam int FLG_PV = 2;
  localparam int FLG_N  = 1;
  localparam int FLG_C  = 0;

  // Status bit positions
  localparam int STAT_BUSY  = 0;
  localparam int STAT_BADOP = 1;
  localparam int STAT_DONE_LO = 8;

  // Reset values
  localparam logic [15:0] PAIR_RST  = 16'h0000;
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [7:0]  IIO_RST   = 8'h00;

  // Second opcode bytes
  localparam logic [7:0] OP_OINC     = 8'h83;
  localparam logic [7:0] OP_MUL_MASK = 8'hCF;
  localparam logic [7:0] OP_MUL_PAT  = 8'h4C;
  localparam int         SEL_HI      = 5;
  localparam int         SEL_LO      = 4;

  // Timing in clock states, counted from the first execute cycle
  localparam logic [4:0] OINC_STATES = 5'h0E;
  localparam logic [4:0] MUL_STATES  = 5'h11;
  localparam logic [4:0] OINC_RD_ST  = 5'h04;
  localparam logic [4:0] OINC_CAP_ST = 5'h06;
  localparam logic [4:0] OINC_WR_ST  = 5'h09;

  // Internal I/O page base for the mirrored registers
  localparam logic [7:0] IIO_BASE = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    XMB_IDLE = 2'b00,
    XMB_MUL  = 2'b01,
    XMB_OINC = 2'b10
  } xmb_state_t;

  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } xmb_mem_req_t;

  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  data;
  } xmb_io_wr_t;

endpackage : xmb_pkg

// >>> core/xmb_dec_flags.sv
/*
  Count decrement and flag builder for the output-increment step.
  Assumes its inputs are stable register values on the caller's clock.
*/
`timescale 1ns/1ns
module xmb_dec_flags (
  input  wire logic [7:0] count_in,
  input  wire logic [7:0] mem_byte,
  input  wire logic [7:0] flags_in,
  output logic      [7:0] count_out,
  output logic      [7:0] flags_out
);

  // Decrement and flag terms; bits 5 and 3 pass through untouched
  always_comb begin
    count_out = count_in - 8'h01;
    flags_out = flags_in;
    flags_out[xmb_pkg::FLG_Z]  = (count_out == 8'h00);
    flags_out[xmb_pkg::FLG_C]  = (count_in == 8'h00);
    flags_out[xmb_pkg::FLG_H]  = (count_in[3:0] == 4'h0);
    flags_out[xmb_pkg::FLG_PV] = ~^count_out;
    flags_out[xmb_pkg::FLG_S]  = count_out[7];
    flags_out[xmb_pkg::FLG_N]  = mem_byte[7];               // Moved byte sign
  end

endmodule : xmb_dec_flags

// >>> core/xmb_exec.sv
/*
  Executor for the unsigned pair multiply and the output-increment-memory
  instruction, with registers reached over AXI4-Lite.
  Assumes mem_rdata is valid the cycle after mem_req.rd is high, and that
  the I/O bus takes io_out.wr as a one-cycle write strobe.
*/
// Notes on behaviour
// - Multiply upper by lower byte of the pair; 16-bit product back into it.
// - Output step reads byte at pointer pair, writes it to port register location.
// - Afterwards pointer pair plus one, port plus one, count minus one.
// - I/O address has upper byte zero and port register in lower byte.
// - Internal I/O register hit is written and still shown on external bus.
// - Zero flag set when count reaches zero, else cleared.
// - Carry flag set when the count decrement borrows, else cleared.
// - Half-carry set when the decrement borrows from bit 4, else cleared.
// - Parity flag set when the new count has even ones, else cleared.
// - Sign flag follows the top bit of the new count.
// - Output step is ED 83, two bytes, fourteen states.
// - Selector codes 00,01,10,11 pick BC, DE, pointer pair, stack pointer.
// - Upper byte of a pair is its high half, lower byte its low half.
`timescale 1ns/1ns
module xmb_exec #(
  parameter int IIO_NUM = 4
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output xmb_pkg::xmb_mem_req_t      mem_req,
  input  wire logic [7:0]            mem_rdata,
  output xmb_pkg::xmb_io_wr_t        io_out,
  output logic                       busy
);

  localparam int IIO_IW = $clog2(IIO_NUM);

  xmb_pkg::xmb_state_t   state_q, state_d;
  logic [4:0]            cnt_q, cnt_d;
  logic [15:0]           pair_q [4];
  logic [15:0]           pair_d [4];
  logic [7:0]            iio_q [IIO_NUM];
  logic [7:0]            iio_d [IIO_NUM];
  logic [7:0]            flags_q, flags_d;
  logic [7:0]            data_q, data_d;
  logic [1:0]            sel_q, sel_d;
  logic                  badop_q, badop_d;
  logic [7:0]            done_q, done_d;
  xmb_pkg::xmb_mem_req_t mem_q, mem_d;
  xmb_pkg::xmb_io_wr_t   io_q, io_d;
  logic                  aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0]            aw_addr_q, aw_addr_d;
  logic [31:0]           w_data_q, w_data_d;
  logic [3:0]            w_strb_q, w_strb_d;
  logic                  bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]            bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]           rdata_q, rdata_d;
  logic [7:0]            count_new, flags_new, port_off, w_off, r_off;
  logic [15:0]           sel_pair;
  logic                  idle;

  // Decrement and flags for the output step
  xmb_dec_flags u_dec (
    .count_in  (pair_q[xmb_pkg::PAIR_BC][15:8]),
    .mem_byte  (data_q),
    .flags_in  (flags_q),
    .count_out (count_new),
    .flags_out (flags_new)
  );

  // Handshake outputs and plain views of state
  assign idle          = (state_q == xmb_pkg::XMB_IDLE);
  assign busy          = ~idle;
  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready  = ~w_have_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign mem_req       = mem_q;
  assign io_out        = io_q;
  assign sel_pair      = pair_q[sel_q];
  assign port_off      = pair_q[xmb_pkg::PAIR_BC][7:0] - xmb_pkg::IIO_BASE;
  assign w_off         = {2'b00, aw_addr_q[7:2]} - {2'b00, xmb_pkg::ADDR_IIO[7:2]};
  assign r_off         = {2'b00, s_axi_araddr[7:2]} - {2'b00, xmb_pkg::ADDR_IIO[7:2]};

  // Byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
    logic [15:0] r;
    r = old;
    if (st[0]) r[7:0] = wd[7:0];
    if (st[1]) r[15:8] = wd[15:8];
    return r;
  endfunction : merge16

  // Next state of bus slave and executor; register writes only land while idle
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    pair_d    = pair_q;
    iio_d     = iio_q;
    flags_d   = flags_q;
    data_d    = data_q;
    sel_d     = sel_q;
    badop_d   = badop_q;
    done_d    = done_q;
    mem_d     = mem_q;
    mem_d.rd  = 1'b0;
    io_d      = io_q;
    io_d.wr   = 1'b0;
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // Both halves held: perform the write and answer
    if (aw_have_q && w_have_q) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = xmb_pkg::RESP_OKAY;
      case (aw_addr_q[7:2])
        xmb_pkg::ADDR_BC[7:2], xmb_pkg::ADDR_DE[7:2],
        xmb_pkg::ADDR_PTR[7:2], xmb_pkg::ADDR_SP[7:2]: begin
          if (idle) pair_d[aw_addr_q[3:2]] = merge16(pair_q[aw_addr_q[3:2]], w_data_q, w_strb_q);
        end
        xmb_pkg::ADDR_FLAGS[7:2]: begin
          if (idle && w_strb_q[0]) flags_d = w_data_q[7:0];
        end
        xmb_pkg::ADDR_CMD[7:2]: begin
          // Second opcode byte starts the instruction; busy drops the command
          if (idle && w_strb_q[0]) begin
            cnt_d   = 5'h00;
            badop_d = 1'b0;
            if (w_data_q[7:0] == xmb_pkg::OP_OINC) begin
              state_d = xmb_pkg::XMB_OINC;
            end else if ((w_data_q[7:0] & xmb_pkg::OP_MUL_MASK) == xmb_pkg::OP_MUL_PAT) begin
              state_d = xmb_pkg::XMB_MUL;
              sel_d   = w_data_q[xmb_pkg::SEL_HI:xmb_pkg::SEL_LO];
            end else begin
              badop_d = 1'b1;
            end
          end
        end
        xmb_pkg::ADDR_STATUS[7:2]: begin
        end
        default: begin
          if (w_off >= 8'(IIO_NUM)) bresp_d = xmb_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    // Read answer, registered one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = xmb_pkg::RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      case (s_axi_araddr[7:2])
        xmb_pkg::ADDR_BC[7:2], xmb_pkg::ADDR_DE[7:2],
        xmb_pkg::ADDR_PTR[7:2], xmb_pkg::ADDR_SP[7:2]: rdata_d[15:0] = pair_q[s_axi_araddr[3:2]];
        xmb_pkg::ADDR_FLAGS[7:2]:  rdata_d[7:0] = flags_q;
        xmb_pkg::ADDR_CMD[7:2]:    rdata_d[1:0] = sel_q;
        xmb_pkg::ADDR_STATUS[7:2]: begin
          rdata_d[xmb_pkg::STAT_BUSY]  = busy;
          rdata_d[xmb_pkg::STAT_BADOP] = badop_q;
          rdata_d[xmb_pkg::STAT_DONE_LO +: 8] = done_q;
        end
        default: begin
          if (r_off < 8'(IIO_NUM)) rdata_d[7:0] = iio_q[r_off[IIO_IW-1:0]];
          else rresp_d = xmb_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Instruction sequencing, one state per clock
    case (state_q)
      xmb_pkg::XMB_IDLE: begin
      end
      xmb_pkg::XMB_MUL: begin
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == xmb_pkg::MUL_STATES - 5'h01) begin
          pair_d[sel_q] = {8'h00, sel_pair[15:8]} * {8'h00, sel_pair[7:0]};
          state_d = xmb_pkg::XMB_IDLE;
          cnt_d   = 5'h00;
          done_d  = done_q + 8'h01;
        end
      end
      xmb_pkg::XMB_OINC: begin
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == xmb_pkg::OINC_RD_ST) begin
          mem_d.rd   = 1'b1;
          mem_d.addr = pair_q[xmb_pkg::PAIR_PTR];
        end
        if (cnt_q == xmb_pkg::OINC_CAP_ST) data_d = mem_rdata;
        if (cnt_q == xmb_pkg::OINC_WR_ST) begin
          io_d.wr   = 1'b1;
          io_d.addr = {8'h00, pair_q[xmb_pkg::PAIR_BC][7:0]};
          io_d.data = data_q;
          // Internal hit is stored here and still strobed outside
          if (port_off < 8'(IIO_NUM)) iio_d[port_off[IIO_IW-1:0]] = data_q;
        end
        if (cnt_q == xmb_pkg::OINC_STATES - 5'h01) begin
          pair_d[xmb_pkg::PAIR_PTR] = pair_q[xmb_pkg::PAIR_PTR] + 16'h0001;
          pair_d[xmb_pkg::PAIR_BC]  = {count_new, pair_q[xmb_pkg::PAIR_BC][7:0] + 8'h01};
          flags_d = flags_new;
          state_d = xmb_pkg::XMB_IDLE;
          cnt_d   = 5'h00;
          done_d  = done_q + 8'h01;
        end
      end
      default: state_d = xmb_pkg::XMB_IDLE;
    endcase
  end

  // Registers only
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= xmb_pkg::XMB_IDLE;
      cnt_q     <= 5'h00;
      for (int i = 0; i < 4; i++) pair_q[i] <= xmb_pkg::PAIR_RST;
      for (int i = 0; i < IIO_NUM; i++) iio_q[i] <= xmb_pkg::IIO_RST;
      flags_q   <= xmb_pkg::FLAGS_RST;
      data_q    <= 8'h00;
      sel_q     <= 2'b00;
      badop_q   <= 1'b0;
      done_q    <= 8'h00;
      mem_q     <= '0;
      io_q      <= '0;
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'b00;
      rvalid_q  <= 1'b0;
      rresp_q   <= 2'b00;
      rdata_q   <= 32'h0000_0000;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      pair_q    <= pair_d;
      iio_q     <= iio_d;
      flags_q   <= flags_d;
      data_q    <= data_d;
      sel_q     <= sel_d;
      badop_q   <= badop_d;
      done_q    <= done_d;
      mem_q     <= mem_d;
      io_q      <= io_d;
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q  <= w_have_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // Checks on the executor; helpers mark first and last execute cycles
  logic oinc_start, oinc_end, mul_start, mul_end;
  assign oinc_start = (state_q == xmb_pkg::XMB_OINC) && (cnt_q == 5'h00);
  assign oinc_end   = (state_q == xmb_pkg::XMB_OINC) && (cnt_q == xmb_pkg::OINC_STATES - 5'h01);
  assign mul_start  = (state_q == xmb_pkg::XMB_MUL) && (cnt_q == 5'h00);
  assign mul_end    = (state_q == xmb_pkg::XMB_MUL) && (cnt_q == xmb_pkg::MUL_STATES - 5'h01);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_mul_product: assert property (mul_end |=> sel_pair == ($past(sel_pair[15:8]) *
      $past(sel_pair[7:0]))) else $error("Pair does not hold the product");
  // Flags at the first state compared with flags one cycle after the last, so a flag change that lasts to the end of the multiply is caught
  a_mul_flags_kept: assert property (mul_start |-> ##17 flags_q == $past(flags_q, 17))
    else $error("Multiply changed the flags");
  a_mem_from_ptr: assert property (mem_q.rd |-> mem_q.addr == pair_q[xmb_pkg::PAIR_PTR])
    else $error("Memory read not at pointer pair");
  a_io_address: assert property (io_q.wr |-> io_q.addr[15:8] == 8'h00 &&
      io_q.addr[7:0] == pair_q[xmb_pkg::PAIR_BC][7:0]) else $error("Bad I/O address");
  // Count and port step as separate bytes: no carry from port into count
  a_oinc_step: assert property (oinc_end |=>
      pair_q[xmb_pkg::PAIR_PTR] == $past(pair_q[xmb_pkg::PAIR_PTR]) + 16'h0001 &&
      pair_q[xmb_pkg::PAIR_BC][15:8] == $past(pair_q[xmb_pkg::PAIR_BC][15:8]) - 8'h01 &&
      pair_q[xmb_pkg::PAIR_BC][7:0] == $past(pair_q[xmb_pkg::PAIR_BC][7:0]) + 8'h01)
    else $error("Pointer, port or count stepped wrongly");
  a_iio_mirror: assert property (io_q.wr && (io_q.addr[7:0] - xmb_pkg::IIO_BASE) < 8'(IIO_NUM)
      |-> iio_q[port_off[IIO_IW-1:0]] == io_q.data) else $error("Internal I/O not updated");
  a_zero_carry: assert property (oinc_end |=>
      flags_q[xmb_pkg::FLG_Z] == (pair_q[xmb_pkg::PAIR_BC][15:8] == 8'h00) &&
      flags_q[xmb_pkg::FLG_C] == (pair_q[xmb_pkg::PAIR_BC][15:8] == 8'hFF))
    else $error("Zero or carry flag wrong");
  a_half_flag: assert property (oinc_end |=> flags_q[xmb_pkg::FLG_H] ==
      ($past(pair_q[xmb_pkg::PAIR_BC][11:8]) == 4'h0)) else $error("Half-carry flag wrong");
  a_parity_sign: assert property (oinc_end |=>
      flags_q[xmb_pkg::FLG_PV] == ~^pair_q[xmb_pkg::PAIR_BC][15:8] &&
      flags_q[xmb_pkg::FLG_S] == pair_q[xmb_pkg::PAIR_BC][15])
    else $error("Parity or sign flag wrong");
  a_oinc_length: assert property (oinc_start |-> ##13 oinc_end ##1 idle)
    else $error("Output step not fourteen states");
  a_mul_select: assert property (mul_start |-> ##16 (mul_end &&
      sel_q == $past(sel_q, 16))) else $error("Pair selector changed");

endmodule : xmb_exec

// >>> verification/xmb_bus_model.sv
/*
  Behavioural memory and I/O devices on the far side of the executor.
  Assumes mem_req.rd is a one-cycle pulse and io_out.wr a one-cycle strobe.
*/
`timescale 1ns/1ns
module xmb_bus_model (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire xmb_pkg::xmb_mem_req_t mem_req,
  output logic [7:0]                 mem_rdata,
  input  wire xmb_pkg::xmb_io_wr_t   io_out,
  output xmb_pkg::xmb_io_wr_t        io_seen,
  output logic [7:0]                 io_cnt
);
  // Memory byte is a fixed mix of its address; external port logs each write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mem_rdata <= 8'h00;
      io_seen   <= '0;
      io_cnt    <= 8'h00;
    end else begin
      if (mem_req.rd) begin
        mem_rdata <= mem_req.addr[7:0] ^ mem_req.addr[15:8] ^ 8'h3C;
      end else begin
        mem_rdata <= ~mem_rdata;  // Stale byte toggles so a late sample is caught
      end
      if (io_out.wr) begin
        io_seen <= io_out;
        io_cnt  <= io_cnt + 8'h01;
      end
    end
  end
endmodule : xmb_bus_model

// >>> verification/tb.sv
/*
  Self-checking bench: multiply and output-increment rows, then awkward cases.
  Assumes the bus model answers memory reads the cycle after the request.
*/
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic [15:0] bc;
    logic [15:0] ptr;
    logic [7:0]  fin;
    logic [15:0] ebc;
    logic [15:0] eptr;
    logic [7:0]  ef;
    logic [7:0]  eb;
  } xmb_orow_t;
  // Multiply rows: opcode, pair address, start value, product
  localparam logic [47:0] MROW [4] = '{48'h4C_00_FFFF_FE01, 48'h5C_04_0C0A_0078,
                                       48'h6C_08_1010_0100, 48'h7C_0C_007F_0000};
  localparam xmb_orow_t OROW [4] = '{
    '{16'h0105, 16'h2000, 8'h00, 16'h0006, 16'h2001, 8'h44, 8'h1C},
    '{16'h00FF, 16'hFFFF, 8'h28, 16'hFF00, 16'h0000, 8'hBD, 8'h3C},
    '{16'h1002, 16'h1234, 8'hFF, 16'h0F03, 16'h1235, 8'h3C, 8'h1A},
    '{16'h8340, 16'h0080, 8'h00, 16'h8241, 16'h0081, 8'h86, 8'hBC}};
  logic                  clk_sys;
  logic                  rst_b;
  logic [7:0]            s_axi_awaddr;
  logic [7:0]            s_axi_araddr;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0]           s_axi_wdata;
  logic [31:0]           s_axi_rdata;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                  s_axi_rvalid, s_axi_rready, busy;
  logic [7:0]            mem_rdata, io_cnt, blen, last_len;
  xmb_pkg::xmb_mem_req_t mem_req;
  xmb_pkg::xmb_io_wr_t   io_out, io_seen;
  logic [31:0]           rd_data;
  logic [1:0]            rsp;
  int                    fail_count, total_checks, cyc;

  xmb_exec #(.IIO_NUM(4)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .io_out(io_out), .busy(busy));

  xmb_bus_model part (
    .clk_sys(clk_sys), .rst_b(rst_b), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .io_out(io_out), .io_seen(io_seen), .io_cnt(io_cnt));

  // Free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // Busy run length, plus a hang guard well above the expected run
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (rst_b !== 1'b1) begin
      blen     <= 8'h00;
      last_len <= 8'h00;
    end else if (busy === 1'b1) blen <= blen + 8'h01;
    else if (blen != 8'h00) begin
      last_len <= blen;
      blen     <= 8'h00;
    end
    if (cyc == 5000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One write; address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    rd_data = s_axi_rdata;
    rsp     = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // Issue a second opcode byte and wait, bounded, until the core is idle
  task automatic run_cmd(input logic [7:0] op);
    int n;
    n = 0;
    axi_wr(xmb_pkg::ADDR_CMD, {24'h000000, op});
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : run_cmd

  // Main sequence
  initial begin
    logic [7:0] n0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {fail_count, total_checks} = '0;
    rst_b    = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      axi_wr(xmb_pkg::ADDR_FLAGS, 32'h000000D5);
      axi_wr(MROW[i][39:32], {16'h0000, MROW[i][31:16]});
      run_cmd(MROW[i][47:40]);
      axi_rd(MROW[i][39:32]);
      chk("product", rd_data, {16'h0000, MROW[i][15:0]});
      axi_rd(xmb_pkg::ADDR_FLAGS);
      chk("multiply flags", rd_data, 32'h000000D5);
      chk("multiply states", {24'h000000, last_len}, 32'h00000011);
    end
    for (int i = 0; i < 4; i++) begin
      axi_wr(xmb_pkg::ADDR_BC, {16'h0000, OROW[i].bc});
      axi_wr(xmb_pkg::ADDR_PTR, {16'h0000, OROW[i].ptr});
      axi_wr(xmb_pkg::ADDR_FLAGS, {24'h000000, OROW[i].fin});
      n0 = io_cnt;
      run_cmd(xmb_pkg::OP_OINC);
      chk("io address", {16'h0000, io_seen.addr}, {24'h000000, OROW[i].bc[7:0]});
      chk("io data", {24'h000000, io_seen.data}, {24'h000000, OROW[i].eb});
      chk("io writes", {24'h000000, io_cnt}, {24'h000000, n0 + 8'h01});
      axi_rd(xmb_pkg::ADDR_BC);
      chk("count and port", rd_data, {16'h0000, OROW[i].ebc});
      axi_rd(xmb_pkg::ADDR_PTR);
      chk("pointer", rd_data, {16'h0000, OROW[i].eptr});
      axi_rd(xmb_pkg::ADDR_FLAGS);
      chk("step flags", rd_data, {24'h000000, OROW[i].ef});
      chk("step states", {24'h000000, last_len}, 32'h0000000E);
    end
    axi_rd(xmb_pkg::ADDR_IIO + 8'h08);
    chk("internal port", rd_data, 32'h0000001A);
    // A command landing while busy must not start a second step
    axi_wr(xmb_pkg::ADDR_PTR, 32'h00000100);
    axi_wr(xmb_pkg::ADDR_CMD, 32'h00000083);
    run_cmd(xmb_pkg::OP_OINC);
    axi_rd(xmb_pkg::ADDR_PTR);
    chk("single step", rd_data, 32'h00000101);
    // Unmapped word answers an error both ways
    axi_rd(8'h1C);
    chk("hole read", {28'h0000000, rsp, 2'b00}, {28'h0000000, xmb_pkg::RESP_SLVERR, 2'b00});
    chk("hole data", rd_data, 32'h00000000);
    axi_wr(8'h1C, 32'h12345678);
    chk("hole write", {30'h00000000, rsp}, {30'h00000000, xmb_pkg::RESP_SLVERR});
    // Unknown opcode is flagged; nine instructions done; last selector was the stack pointer
    axi_wr(xmb_pkg::ADDR_CMD, 32'h00000000);
    axi_rd(xmb_pkg::ADDR_STATUS);
    chk("bad opcode", rd_data, 32'h00000902);
    axi_rd(xmb_pkg::ADDR_CMD);
    chk("last selector", rd_data, 32'h00000003);
    // Strobe on the upper lane alone changes only the upper byte
    s_axi_wstrb <= 4'h2;
    axi_wr(xmb_pkg::ADDR_DE, 32'h0000ABCD);
    s_axi_wstrb <= 4'hF;
    axi_rd(xmb_pkg::ADDR_DE);
    chk("upper lane", rd_data, 32'h0000AB78);
    // Reset lands while a multiply runs; it clears pairs, flags, status and internal ports
    axi_wr(xmb_pkg::ADDR_CMD, 32'h0000004C);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    axi_rd(xmb_pkg::ADDR_BC);
    chk("reset pair", rd_data, 32'h00000000);
    axi_rd(xmb_pkg::ADDR_STATUS);
    chk("reset status", rd_data, 32'h00000000);
    axi_rd(xmb_pkg::ADDR_FLAGS);
    chk("reset flags", rd_data, 32'h00000000);
    axi_rd(xmb_pkg::ADDR_IIO + 8'h08);
    chk("reset port", rd_data, 32'h00000000);
    end_of_test();
  end
endmodule : tb
